// File: include/charger_ctrl_pkg.sv
// Constants for the charger control register group
package charger_ctrl_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_RESET_IDENTITY   = 8'h0B;
  localparam logic [7:0] ADDR_TEMP_PROFILE     = 8'h0C;
  localparam logic [7:0] ADDR_PULSE_DATALINE   = 8'h0D;
  localparam logic [7:0] ADDR_DETECT_STATUS    = 8'h0E;
  localparam logic [7:0] ADDR_FAULT_STATUS     = 8'h09;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] TEMP_PROFILE_RESET    = 8'h75;
  localparam logic [7:0] PULSE_DATALINE_RESET  = 8'h01;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_REG_RESET       = 7;
  localparam int POS_PART_ID         = 3;
  localparam int POS_REVISION        = 0;
  localparam int POS_COOL_VCAP       = 7;
  localparam int POS_COOL_EN         = 6;
  localparam int POS_WARM_ISCALE     = 4;
  localparam int POS_COOL_THR        = 2;
  localparam int POS_WARM_THR        = 0;
  localparam int POS_PULSE_EN        = 7;
  localparam int POS_PULSE_UP        = 6;
  localparam int POS_PULSE_DN        = 5;
  localparam int POS_DPLUS           = 3;
  localparam int POS_DMINUS          = 1;
  localparam int POS_FREQ_TERM       = 0;
  localparam int POS_DETECT_DONE     = 7;
  localparam int POS_WDOG_FAULT      = 7;
  // ****************************************
  // Encodings and timing
  // ****************************************
  localparam logic [1:0] DRIVE_HIZ           = 2'h0;
  localparam logic [5:0] CHARGE_CODE_300MA   = 6'h05;
  localparam logic [3:0] TERM_SCALE          = 4'h6;
  // Pulse sequence length, in ns and derived clock cycles
  localparam int CLK_PERIOD_NS     = 10;
  localparam int PULSE_SEQ_NS      = 1000;
  localparam int PULSE_SEQ_CYCLES  = (PULSE_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: logic/pulse_sequencer.sv
// Current pulse sequence timer for the adapter voltage signalling
`timescale 1ns/10ps
`default_nettype none
module pulse_sequencer
  import charger_ctrl_pkg::*;
#(
  parameter int SEQ_CYCLES = PULSE_SEQ_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic request,
  output logic      busy,
  output logic      done
);
  typedef enum logic [0:0] {IDLE, RUN} seq_state_t;
  typedef struct packed {
    seq_state_t  state;
    logic [15:0] count;
    logic        done;
  } seq_t;

  seq_t cur;
  seq_t next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.done = 1'b0;
    unique case (cur.state)
      IDLE: begin
        // Request clears a cycle after done; do not start it twice
        if (request && enable && !cur.done) begin
          next_cur.state = RUN;
          next_cur.count = 16'h0000;
        end
      end
      RUN: begin
        // Dropping the enable aborts and releases the request
        if (!enable || cur.count == 16'(SEQ_CYCLES - 1)) begin
          next_cur.state = IDLE;
          next_cur.done  = 1'b1;
        end else begin
          next_cur.count = cur.count + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '{state: IDLE, count: 16'h0000, done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = (cur.state == RUN);
  assign done = cur.done;
endmodule
`default_nettype wire

// File: logic/charger_control_regs.sv
// Charger control, identification and signalling register group
//
// Behaviour
// R01: Writing one to reset bit restores all writable defaults and restarts safety timer.
// R02: Reset bit clears itself after the register reset completes.
// R03: Writing zero to reset bit changes nothing; it reads zero by default.
// R04: Cool voltage cap selects lower of 4.1V and programmed target in cool band.
// R05: Cool band charge enable allows charging when one, inhibits when zero.
// R06: Warm current field scales charge current 0/20/50/100 percent, default 100.
// R07: Warm band charging never doubles the safety timer.
// R08: Cool threshold field selects one of four ratios, default code 01.
// R09: Warm threshold field selects one of four ratios, default code 01.
// R10: Pulse enable gates up and down pulse sequences; default zero.
// R11: Up/down request bits set only while pulse enable already set.
// R12: Request bit clears itself when its pulse sequence completes.
// R13: D+ drive field selects hiz, 0V, 0.6V or 3.3V, default hiz.
// R14: D- drive field selects hiz, 0V, 0.6V or 3.3V, default hiz.
// R15: Input plug-in forces D+/D- fields to default until detection done.
// R16: Shared bit selects boost frequency 500kHz at zero, 1.5MHz at one.
// R17: Shared bit zero scales termination code by six when charge current exceeds 300mA; the code scales only while boost_mode is low.
// R18: Detection done flag rises when input detection finishes.
// R19: Watchdog fault bit reads one after the host watchdog expired.
// R20: Profile, pulse, drive and shared fields default on reset or watchdog expiry.
// R21: Part and revision fields are constants, immune to writes and reset.
`timescale 1ns/10ps
`default_nettype none
module charger_control_regs
  import charger_ctrl_pkg::*;
#(
  parameter logic [3:0] PART_ID     = 4'h5, // Arbitrary value
  parameter logic [1:0] REVISION    = 2'h2, // Arbitrary value
  parameter int         SEQ_CYCLES  = PULSE_SEQ_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Charger core status and settings
  input  wire logic       watchdog_expired,
  input  wire logic       input_plugged,
  input  wire logic       detection_finished,
  input  wire logic       boost_mode,
  input  wire logic [5:0] charge_current_code,
  input  wire logic [3:0] termination_current_code,
  // Control outputs
  output logic            safety_timer_restart,
  output logic            cool_band_voltage_cap,
  output logic            cool_band_charge_enable,
  output logic      [1:0] warm_band_current_scale,
  output logic            warm_timer_double_allow,
  output logic      [1:0] cool_threshold_select,
  output logic      [1:0] warm_threshold_select,
  output logic            pulse_up_active,
  output logic            pulse_down_active,
  output logic      [1:0] dplus_drive_level,
  output logic      [1:0] dminus_drive_level,
  output logic            boost_freq_high,
  output logic      [7:0] effective_termination_code
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic       reset_busy;
    logic [7:0] temp_profile;
    logic [7:0] pulse_dataline;
    logic       dataline_locked;
    logic       plugged_prev;
    logic       detection_complete_flag;
    logic       watchdog_fault;
    logic [7:0] rdata;
    logic       timer_restart;
    logic       cool_vcap;
    logic       cool_en;
    logic [1:0] warm_scale;
    logic [1:0] cool_thr;
    logic [1:0] warm_thr;
    logic       up_active;
    logic       dn_active;
    logic [1:0] dplus;
    logic [1:0] dminus;
    logic       freq_high;
    logic [7:0] term_code;
  } regs_t;

  regs_t cur;
  regs_t next_cur;

  logic up_busy;
  logic up_done;
  logic dn_busy;
  logic dn_done;

  // ****************************************
  // Pulse sequencers
  // ****************************************
  pulse_sequencer #(.SEQ_CYCLES(SEQ_CYCLES)) u_seq_up (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (cur.pulse_dataline[POS_PULSE_EN]),
    .request (cur.pulse_dataline[POS_PULSE_UP]),
    .busy    (up_busy),
    .done    (up_done)
  );

  pulse_sequencer #(.SEQ_CYCLES(SEQ_CYCLES)) u_seq_dn (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (cur.pulse_dataline[POS_PULSE_EN]),
    .request (cur.pulse_dataline[POS_PULSE_DN]),
    .busy    (dn_busy),
    .done    (dn_done)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] wv;
    logic       pulse_on;
    wv                = reg_wdata;
    pulse_on          = cur.pulse_dataline[POS_PULSE_EN];
    next_cur          = cur;
    next_cur.reset_busy    = 1'b0;
    next_cur.timer_restart = 1'b0;

    // Host writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_RESET_IDENTITY: begin
          if (wv[POS_REG_RESET]) begin
            next_cur.reset_busy    = 1'b1;                             // R01
          end                                                          // R03
        end
        ADDR_TEMP_PROFILE: begin
          next_cur.temp_profile = wv;
        end
        ADDR_PULSE_DATALINE: begin
          next_cur.pulse_dataline = wv;
          // Requests latch only if enable was already set
          next_cur.pulse_dataline[POS_PULSE_UP] = (wv[POS_PULSE_UP] && pulse_on)
                                                  || cur.pulse_dataline[POS_PULSE_UP]; // R11
          next_cur.pulse_dataline[POS_PULSE_DN] = (wv[POS_PULSE_DN] && pulse_on)
                                                  || cur.pulse_dataline[POS_PULSE_DN]; // R11
          if (cur.dataline_locked) begin
            next_cur.pulse_dataline[POS_DPLUS +: 2]  = DRIVE_HIZ;      // R15
            next_cur.pulse_dataline[POS_DMINUS +: 2] = DRIVE_HIZ;      // R15
          end
        end
        default: begin
        end
      endcase
    end

    // Sequence completion clears the request
    if (up_done) begin
      next_cur.pulse_dataline[POS_PULSE_UP] = 1'b0;                    // R12
    end
    if (dn_done) begin
      next_cur.pulse_dataline[POS_PULSE_DN] = 1'b0;                    // R12
    end

    // Plug-in forces drive defaults and holds them until detection ends
    // Edge, not level: a source left plugged must not re-lock after detection
    if (input_plugged && !cur.plugged_prev && !detection_finished) begin
      next_cur.dataline_locked = 1'b1;                                 // R15
    end
    next_cur.plugged_prev = input_plugged;
    if (cur.dataline_locked) begin
      next_cur.pulse_dataline[POS_DPLUS +: 2]  = DRIVE_HIZ;            // R15
      next_cur.pulse_dataline[POS_DMINUS +: 2] = DRIVE_HIZ;            // R15
      if (detection_finished) begin
        next_cur.dataline_locked = 1'b0;
      end
    end

    // Detection flag: set wins; a new plug-in rearms it
    if (detection_finished) begin
      next_cur.detection_complete_flag = 1'b1;                         // R18
    end else if (input_plugged && !cur.plugged_prev) begin
      next_cur.detection_complete_flag = 1'b0;
    end
    if (!input_plugged && !detection_finished) begin
      next_cur.detection_complete_flag = 1'b0;
    end

    // Watchdog fault is sticky until read, set wins over the read clear
    if (reg_rd && reg_addr == ADDR_FAULT_STATUS) begin
      next_cur.watchdog_fault = 1'b0;
    end
    if (watchdog_expired) begin
      next_cur.watchdog_fault = 1'b1;                                  // R19
    end

    // Global reset or watchdog expiry restore defaults
    if (cur.reset_busy || watchdog_expired) begin
      next_cur.temp_profile   = TEMP_PROFILE_RESET;                    // R20
      next_cur.pulse_dataline = PULSE_DATALINE_RESET;                  // R20
    end
    if (cur.reset_busy) begin
      next_cur.timer_restart  = 1'b1;                                  // R01
    end

    // Read data
    unique case (reg_addr)
      ADDR_RESET_IDENTITY: begin
        // Reset bit reads zero once the reset completes
        next_cur.rdata = {1'b0, PART_ID, 1'b0, REVISION};              // R02 R21
      end
      ADDR_TEMP_PROFILE:   next_cur.rdata = cur.temp_profile;
      ADDR_PULSE_DATALINE: next_cur.rdata = cur.pulse_dataline;
      ADDR_DETECT_STATUS:  next_cur.rdata = {cur.detection_complete_flag, 7'h00};
      ADDR_FAULT_STATUS:   next_cur.rdata = {cur.watchdog_fault, 7'h00};
      default:             next_cur.rdata = 8'h00;
    endcase

    // Decoded controls
    next_cur.cool_vcap  = cur.temp_profile[POS_COOL_VCAP];             // R04
    next_cur.cool_en    = cur.temp_profile[POS_COOL_EN];               // R05
    next_cur.warm_scale = cur.temp_profile[POS_WARM_ISCALE +: 2];      // R06
    next_cur.cool_thr   = cur.temp_profile[POS_COOL_THR +: 2];         // R08
    next_cur.warm_thr   = cur.temp_profile[POS_WARM_THR +: 2];         // R09
    next_cur.up_active  = up_busy && pulse_on;                         // R10
    next_cur.dn_active  = dn_busy && pulse_on;                         // R10
    next_cur.dplus      = cur.pulse_dataline[POS_DPLUS +: 2];          // R13
    next_cur.dminus     = cur.pulse_dataline[POS_DMINUS +: 2];         // R14
    next_cur.freq_high  = cur.pulse_dataline[POS_FREQ_TERM];           // R16
    if (!boost_mode && !cur.pulse_dataline[POS_FREQ_TERM]
        && charge_current_code > CHARGE_CODE_300MA) begin
      next_cur.term_code = {4'h0, termination_current_code} * {4'h0, TERM_SCALE}; // R17
    end else begin
      next_cur.term_code = {4'h0, termination_current_code};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur                <= '0;
      cur.temp_profile   <= TEMP_PROFILE_RESET;
      cur.pulse_dataline <= PULSE_DATALINE_RESET;
      cur.cool_en        <= 1'b1;
      cur.warm_scale     <= 2'h3;
      cur.cool_thr       <= 2'h1;
      cur.warm_thr       <= 2'h1;
      cur.freq_high      <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata                  = cur.rdata;
  assign safety_timer_restart       = cur.timer_restart;
  assign cool_band_voltage_cap      = cur.cool_vcap;
  assign cool_band_charge_enable    = cur.cool_en;
  assign warm_band_current_scale    = cur.warm_scale;
  assign warm_timer_double_allow    = 1'b0;                            // R07
  assign cool_threshold_select      = cur.cool_thr;
  assign warm_threshold_select      = cur.warm_thr;
  assign pulse_up_active            = cur.up_active;
  assign pulse_down_active          = cur.dn_active;
  assign dplus_drive_level          = cur.dplus;
  assign dminus_drive_level         = cur.dminus;
  assign boost_freq_high            = cur.freq_high;
  assign effective_termination_code = cur.term_code;
endmodule
`default_nettype wire

// File: test/charger_regs_asserts.sv
// Concurrent checks on the charger register group ports
`timescale 1ns/10ps
`default_nettype none
module charger_regs_asserts
  import charger_ctrl_pkg::*;
#(
  parameter int SEQ_CYCLES = PULSE_SEQ_CYCLES
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       watchdog_expired,
  input wire logic       input_plugged,
  input wire logic       safety_timer_restart,
  input wire logic       cool_band_voltage_cap,
  input wire logic       cool_band_charge_enable,
  input wire logic [1:0] warm_band_current_scale,
  input wire logic       warm_timer_double_allow,
  input wire logic [1:0] cool_threshold_select,
  input wire logic [1:0] warm_threshold_select,
  input wire logic       pulse_up_active,
  input wire logic       pulse_down_active,
  input wire logic [1:0] dplus_drive_level,
  input wire logic [1:0] dminus_drive_level,
  input wire logic       boost_freq_high
);
  // Slack over the sequence length for pipeline stages
  localparam int RUN_MAX = SEQ_CYCLES + 8;
  logic [7:0] prof;
  logic       act;
  logic       dl_hiz;
  assign prof = {cool_band_voltage_cap, cool_band_charge_enable, warm_band_current_scale,
                 cool_threshold_select, warm_threshold_select};
  assign act = pulse_up_active | pulse_down_active;
  assign dl_hiz = dplus_drive_level == DRIVE_HIZ && dminus_drive_level == DRIVE_HIZ;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Properties
  // ****************************************
  property p_restart;
    reg_wr && reg_addr == ADDR_RESET_IDENTITY && reg_wdata[7] |-> ##[1:3] safety_timer_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("timer restart missing");
  property p_restart_once;
    safety_timer_restart |=> !safety_timer_restart;
  endproperty
  a_restart_once: assert property (p_restart_once) else $error("restart too long");
  property p_no_double;
    warm_timer_double_allow == 1'b0;
  endproperty
  a_no_double: assert property (p_no_double) else $error("warm timer doubled");
  property p_wd_defaults;
    watchdog_expired && !reg_wr |-> ##2 prof == TEMP_PROFILE_RESET && dl_hiz && boost_freq_high;
  endproperty
  a_wd_defaults: assert property (p_wd_defaults) else $error("watchdog defaults");
  property p_fields;
    reg_wr && reg_addr == ADDR_TEMP_PROFILE && !watchdog_expired |-> ##2 prof == $past(reg_wdata, 2);
  endproperty
  a_fields: assert property (p_fields) else $error("profile fields");
  property p_plug;
    $rose(input_plugged) |-> ##3 dl_hiz;
  endproperty
  a_plug: assert property (p_plug) else $error("plug-in drive reset");
  property p_pulse_run;
    $rose(act) |-> act[*3] ##[1:RUN_MAX] !act;
  endproperty
  a_pulse_run: assert property (p_pulse_run) else $error("pulse length");
  property p_pulse_off;
    reg_wr && reg_addr == ADDR_PULSE_DATALINE && !reg_wdata[7] |-> ##2 !act;
  endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pulse not gated");
  c_pulse: cover property ($rose(pulse_up_active));
  c_restart: cover property (safety_timer_restart);
  c_plug: cover property ($rose(input_plugged));
endmodule
`default_nettype wire

// File: test/host_model.sv
// Host controller model for the register port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released data must not look valid
    reg_wdata <= ~v;
  endtask
  // Data taken right after the sampling edge, before a clear-on-read lands
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: test/charger_control_regs_b_to_d_test.sv
// Self-checking bench for the charger register group
`timescale 1ns/10ps
`default_nettype none
module charger_control_regs_b_to_d_test;
  import charger_ctrl_pkg::*;
  logic       clk, sys_rst, reg_wr, reg_rd, watchdog_expired, input_plugged;
  logic       detection_finished, boost_mode, safety_timer_restart, boost_freq_high;
  logic       cool_band_voltage_cap, cool_band_charge_enable, warm_timer_double_allow;
  logic       pulse_up_active, pulse_down_active;
  logic [1:0] warm_band_current_scale, cool_threshold_select, warm_threshold_select;
  logic [1:0] dplus_drive_level, dminus_drive_level;
  logic [3:0] termination_current_code;
  logic [5:0] charge_current_code;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, effective_termination_code, d, v;
  int         err_count, n_checks, seed, i, r;
  charger_control_regs #(.SEQ_CYCLES(4)) dut_u (.*);
  host_model host_u (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_pulse(input logic s);
    int k;
    k = 0;
    while ((pulse_up_active | pulse_down_active) !== s && k < 50) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 50) begin
      err_count++;
      end_of_test();
    end
  endtask
  function automatic logic [7:0] exp_term(logic b, logic s, logic [5:0] c, logic [3:0] t);
    return (!b && !s && c > 6'h05) ? {4'h0, t} * 8'h06 : {4'h0, t};
  endfunction
  initial begin
    seed = 32'h2BA47FB2;
    err_count = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    watchdog_expired = 1'b0;
    input_plugged = 1'b0;
    detection_finished = 1'b0;
    boost_mode = 1'b0;
    charge_current_code = 6'h00;
    termination_current_code = 4'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(ADDR_TEMP_PROFILE, 8'h75);
    rchk(ADDR_PULSE_DATALINE, 8'h01);
    rchk(ADDR_RESET_IDENTITY, 8'h2A);
    host_u.wr(8'h3F, 8'hFF);
    rchk(8'h3F, 8'h00);
    $display("reset values done");
    // Every two-bit code first, then random patterns
    for (i = 0; i < 12; i++) begin
      v = (i < 4) ? {4{i[1:0]}} : 8'($random(seed));
      host_u.wr(ADDR_TEMP_PROFILE, v);
      rchk(ADDR_TEMP_PROFILE, v);
      chk("profile", v, {cool_band_voltage_cap, cool_band_charge_enable,
          warm_band_current_scale, cool_threshold_select, warm_threshold_select});
    end
    host_u.wr(ADDR_RESET_IDENTITY, 8'h7F);
    rchk(ADDR_TEMP_PROFILE, v);
    rchk(ADDR_RESET_IDENTITY, 8'h2A);
    host_u.wr(ADDR_PULSE_DATALINE, 8'h9E);
    host_u.wr(ADDR_RESET_IDENTITY, 8'h80);
    repeat (2) @(posedge clk);
    rchk(ADDR_RESET_IDENTITY, 8'h2A);
    rchk(ADDR_TEMP_PROFILE, 8'h75);
    rchk(ADDR_PULSE_DATALINE, 8'h01);
    $display("register reset done");
    host_u.wr(ADDR_PULSE_DATALINE, 8'hC1);
    rchk(ADDR_PULSE_DATALINE, 8'h81);
    for (i = 0; i < 2; i++) begin
      host_u.wr(ADDR_PULSE_DATALINE, i ? 8'hA1 : 8'hC1);
      wait_pulse(1'b1);
      chk("direction", {6'h00, ~i[0], i[0]}, {6'h00, pulse_up_active, pulse_down_active});
      wait_pulse(1'b0);
      rchk(ADDR_PULSE_DATALINE, 8'h81);
      chk("rerun", 8'h00, {7'h00, pulse_up_active | pulse_down_active});
    end
    // Dropping the enable in the last sequence cycle ends it and frees the request
    host_u.wr(ADDR_PULSE_DATALINE, 8'hC1);
    wait_pulse(1'b1);
    host_u.wr(ADDR_PULSE_DATALINE, 8'h01);
    wait_pulse(1'b0);
    rchk(ADDR_PULSE_DATALINE, 8'h01);
    $display("pulse done");
    host_u.wr(ADDR_PULSE_DATALINE, 8'h19);
    rchk(ADDR_PULSE_DATALINE, 8'h19);
    @(posedge clk) input_plugged <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(ADDR_PULSE_DATALINE, 8'h01);
    host_u.wr(ADDR_PULSE_DATALINE, 8'h1F);
    rchk(ADDR_PULSE_DATALINE, 8'h01);
    @(posedge clk) detection_finished <= 1'b1;
    @(posedge clk) detection_finished <= 1'b0;
    host_u.wr(ADDR_PULSE_DATALINE, 8'h17);
    rchk(ADDR_PULSE_DATALINE, 8'h17);
    chk("drive", 8'h0B, {4'h0, dplus_drive_level, dminus_drive_level});
    host_u.rd(ADDR_DETECT_STATUS, d);
    chk("detect", 8'h80, d & 8'h80);
    $display("data lines done");
    // Charge codes 5 and 6 straddle the scaling threshold
    for (i = 0; i < 16; i++) begin
      r = $random(seed);
      host_u.wr(ADDR_PULSE_DATALINE, {7'h0B, r[1]});
      @(posedge clk);
      boost_mode <= r[0];
      charge_current_code <= (i < 2) ? 6'(5 + i) : r[7:2];
      termination_current_code <= r[11:8];
      repeat (3) @(posedge clk);
      #1 chk("term", exp_term(r[0], r[1], charge_current_code, r[11:8]),
             effective_termination_code);
      chk("freq", {7'h00, r[1]}, {7'h00, boost_freq_high});
    end
    $display("termination done");
    host_u.wr(ADDR_TEMP_PROFILE, 8'h0A);
    @(posedge clk) watchdog_expired <= 1'b1;
    @(posedge clk) watchdog_expired <= 1'b0;
    rchk(ADDR_TEMP_PROFILE, 8'h75);
    rchk(ADDR_PULSE_DATALINE, 8'h01);
    host_u.rd(ADDR_FAULT_STATUS, d);
    chk("wdog", 8'h80, d & 8'h80);
    host_u.rd(ADDR_FAULT_STATUS, d);
    chk("wdog clear", 8'h00, d & 8'h80);
    $display("watchdog done");
    end_of_test();
  end
endmodule
bind charger_control_regs charger_regs_asserts #(.SEQ_CYCLES(SEQ_CYCLES)) chk_u (.*);
`default_nettype wire
